// file: hw/thermal_head_params.svh
// constants for the thermal head line logic
`ifndef THERMAL_HEAD_PARAMS_SVH
`define THERMAL_HEAD_PARAMS_SVH
`define HEAD_DOTS 384
`define HEAD_BLOCKS 6
`define HEAD_BLOCK_DOTS 64
`define HEAD_MAX_HOT_DOTS 45
`define HEAD_CNT_W 9
`define HEAD_SYNC_STAGES 2
`endif

// file: hw/thermal_head_pkg.sv
// types shared by the thermal head line logic
package thermal_head_pkg;
    // pins driven by the controller, as seen at the head
    typedef struct packed {
        logic serial_dot_input;
        logic line_store_strobe_n;
        logic heat_strobe;
    } head_pins_t;
    // status of the line as seen from the system clock
    typedef struct packed {
        logic line_stored;
        logic heating;
        logic over_limit;
    } head_status_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOADED,
        ST_HEAT
    } head_state_t;
endpackage : thermal_head_pkg

// file: hw/bit_sync.sv
// two flip-flop synchroniser for a level
`timescale 1ns/1ps
module bit_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : bit_sync

// file: hw/dot_counter.sv
// population count of a latched line, used to flag over-energy lines
`timescale 1ns/1ps
module dot_counter
#(
    parameter int DOTS = 384,
    parameter int CNT_W = 9
)
(
    input wire logic [DOTS-1:0] bits,
    output logic [CNT_W-1:0] count
);
    // plain adder chain; the line changes rarely so depth is no issue at 10 MHz
    always_comb
    begin
        count = '0;
        for (int i = 0; i < DOTS; i++)
        begin
            count = count + CNT_W'(bits[i]);
        end
    end
endmodule : dot_counter

// file: hw/thermal_head_line.sv
// thermal head: serial line shift, line latch, strobed heating of six blocks
`timescale 1ns/1ps
`include "thermal_head_params.svh"
module thermal_head_line
#(
    parameter int DOTS = `HEAD_DOTS,
    parameter int BLOCKS = `HEAD_BLOCKS,
    parameter int BLOCK_DOTS = `HEAD_BLOCK_DOTS,
    parameter int MAX_HOT = `HEAD_MAX_HOT_DOTS,
    parameter int CNT_W = `HEAD_CNT_W
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic shift_clk,
    input wire logic shift_rstn,
    input wire thermal_head_pkg::head_pins_t pins,
    output logic [DOTS-1:0] element_on,
    output logic [BLOCKS-1:0] block_active,
    output logic [DOTS-1:0] line_image,
    output logic [CNT_W-1:0] hot_dots,
    output thermal_head_pkg::head_status_t status,
    output logic [CNT_W-1:0] bits_shifted
);
    // shift-clock domain: shift register and bit count
    logic [DOTS-1:0] shift_reg;
    logic [CNT_W-1:0] shift_cnt_reg;
    // latch and heat are level pins from outside, synchronised into clk
    logic [1:0] ctl_sync;
    logic latch_n_s;
    logic heat_s;
    logic latch_n_d_reg;
    logic latch_fire;
    logic [DOTS-1:0] latch_reg;
    logic [DOTS-1:0] latch_next;
    logic [CNT_W-1:0] pop_count;
    logic [CNT_W-1:0] pop_reg;
    logic [CNT_W-1:0] cnt_gray_reg;
    logic [CNT_W-1:0] cnt_gray_s;
    thermal_head_pkg::head_state_t state_reg;
    thermal_head_pkg::head_state_t state_next;
    // the count runs over the middle of the gray range, so the wrap from the
    // last bit back to the first is a reflected step that flips a single bit
    localparam int GRAY_BASE = ((1 << CNT_W) - DOTS) / 2;
    localparam logic [CNT_W-1:0] BASE_BIN = CNT_W'(GRAY_BASE);
    localparam logic [CNT_W-1:0] BASE_GRAY = BASE_BIN ^ (BASE_BIN >> 1);
    logic [CNT_W-1:0] cnt_bin_s;
    logic [CNT_W-1:0] bits_next;

    // gray helpers for the bit count crossing
    function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b = '0;
        b[CNT_W-1] = g[CNT_W-1];
        for (int i = CNT_W - 2; i >= 0; i--)
        begin
            b[i] = g[i] ^ b[i + 1];
        end
        gray2bin = b;
    endfunction : gray2bin

    // new bit enters at bit 0, so after a full line bit 1 of the line sits at the top
    always_ff @(posedge shift_clk or negedge shift_rstn)
    begin
        if (!shift_rstn)
        begin
            shift_reg <= '0;
        end
        else
        begin
            shift_reg <= {shift_reg[DOTS-2:0], pins.serial_dot_input};
        end
    end

    // bit count wraps at a line; published gray coded so it crosses safely
    always_ff @(posedge shift_clk or negedge shift_rstn)
    begin
        if (!shift_rstn)
        begin
            shift_cnt_reg <= '0;
            cnt_gray_reg <= BASE_GRAY;
        end
        else
        begin
            if (shift_cnt_reg == CNT_W'(DOTS - 1))
            begin
                shift_cnt_reg <= '0;
                cnt_gray_reg <= BASE_GRAY;
            end
            else
            begin
                shift_cnt_reg <= shift_cnt_reg + CNT_W'(1);
                cnt_gray_reg <= bin2gray(shift_cnt_reg + CNT_W'(1) + BASE_BIN);
            end
        end
    end

    // count and control levels each pass two flops before clk logic reads them
    bit_sync #(.WIDTH(CNT_W)) u_cnt_sync
    (
        .clk(clk),
        .rstn(rstn),
        .d(cnt_gray_reg),
        .q(cnt_gray_s)
    );

    bit_sync #(.WIDTH(2)) u_ctl_sync
    (
        .clk(clk),
        .rstn(rstn),
        .d({pins.line_store_strobe_n, pins.heat_strobe}),
        .q(ctl_sync)
    );

    // bit 1 carries the store level, bit 0 the heat level
    assign latch_n_s = ctl_sync[1];
    assign heat_s = ctl_sync[0];

    // falling-edge detect on the synchronised latch level
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // reset low, so the sync stages filling with the idle high level
            // cannot look like a falling edge right after reset
            latch_n_d_reg <= 1'b0;
        end
        else
        begin
            latch_n_d_reg <= latch_n_s;
        end
    end

    // one-cycle pulse, a high level must have been seen before the low one
    assign latch_fire = latch_n_d_reg & ~latch_n_s;

    // shift register is taken as a bus: the controller holds the shift clock still
    // across the latch pulse, so the word is stable when the synchronised edge arrives
    // limitation: a store pulse while the shift clock still runs takes a mixed word
    always_comb
    begin
        latch_next = latch_reg;
        if (latch_fire)
        begin
            latch_next = shift_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            latch_reg <= '0;
        end
        else
        begin
            latch_reg <= latch_next;
        end
    end

    dot_counter #(.DOTS(DOTS), .CNT_W(CNT_W)) u_dot_counter
    (
        .bits(latch_reg),
        .count(pop_count)
    );

    // registered once more so the long adder chain stays off the output path
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pop_reg <= '0;
        end
        else
        begin
            pop_reg <= pop_count;
        end
    end

    // line state tracks whether a line is held and whether it is being heated
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            thermal_head_pkg::ST_IDLE:
            begin
                if (latch_fire)
                begin
                    state_next = thermal_head_pkg::ST_LOADED;
                end
            end
            thermal_head_pkg::ST_LOADED:
            begin
                if (heat_s)
                begin
                    state_next = thermal_head_pkg::ST_HEAT;
                end
            end
            thermal_head_pkg::ST_HEAT:
            begin
                if (!heat_s)
                begin
                    state_next = thermal_head_pkg::ST_LOADED;
                end
            end
        endcase
    end

    // state register, cleared to no line held
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= thermal_head_pkg::ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // one strobe drives all blocks; each block shows if any of its dots burns
    genvar gb;
    generate
        for (gb = 0; gb < BLOCKS; gb++)
        begin : g_block
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    element_on[gb*BLOCK_DOTS +: BLOCK_DOTS] <= '0;
                    block_active[gb] <= 1'b0;
                end
                else
                begin
                    // high bit burns, low bit stays blank
                    element_on[gb*BLOCK_DOTS +: BLOCK_DOTS] <=
                        heat_s ? latch_next[gb*BLOCK_DOTS +: BLOCK_DOTS] : '0;
                    block_active[gb] <= heat_s &
                        (|latch_next[gb*BLOCK_DOTS +: BLOCK_DOTS]);
                end
            end
        end
    endgenerate

    // decode the crossed count; the all-zero word seen before the synchroniser
    // fills after reset lies below the base and reads as no bits shifted
    always_comb
    begin
        cnt_bin_s = gray2bin(cnt_gray_s);
        bits_next = '0;
        if (cnt_bin_s >= BASE_BIN)
        begin
            bits_next = cnt_bin_s - BASE_BIN;
        end
    end

    // registered outputs for the system side
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            line_image <= '0;
            hot_dots <= '0;
            status <= '0;
            bits_shifted <= '0;
        end
        else
        begin
            line_image <= latch_reg;
            hot_dots <= pop_reg;
            status.line_stored <= (state_reg != thermal_head_pkg::ST_IDLE);
            status.heating <= (state_reg == thermal_head_pkg::ST_HEAT);
            // flag only; the head cannot limit current itself
            status.over_limit <= (pop_reg > CNT_W'(MAX_HOT));
            bits_shifted <= bits_next;
        end
    end
endmodule : thermal_head_line

// file: tb/thermal_head_line_asserts.sv
// checker of the thermal head outputs against the controller pins
`timescale 1ns/1ps
module thermal_head_line_asserts
#(
    parameter int DOTS = 384,
    parameter int BLOCKS = 6,
    parameter int BLOCK_DOTS = 64,
    parameter int CNT_W = 9
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic shift_clk,
    input wire logic shift_rstn,
    input wire thermal_head_pkg::head_pins_t pins,
    input wire logic [DOTS-1:0] element_on,
    input wire logic [BLOCKS-1:0] block_active,
    input wire logic [DOTS-1:0] line_image,
    input wire logic [CNT_W-1:0] hot_dots,
    input wire thermal_head_pkg::head_status_t status,
    input wire logic [CNT_W-1:0] bits_shifted
);
    logic [BLOCKS-1:0] blk_exp;
    // a block is active when any of its elements is lit
    always_comb
    begin
        for (int b = 0; b < BLOCKS; b++)
        begin
            blk_exp[b] = |element_on[b*BLOCK_DOTS +: BLOCK_DOTS];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // five cycles of margin cover the two sync stages and the output register
    property p_heat_off;
        !pins.heat_strobe [*5] |-> element_on == '0;
    endproperty
    a_heat_off: assert property (p_heat_off) else $error("element lit without strobe");
    property p_heat_on;
        (pins.heat_strobe && $stable(line_image)) [*5] |-> element_on == line_image;
    endproperty
    a_heat_on: assert property (p_heat_on) else $error("lit elements differ from line");
    property p_block;
        $stable(element_on) |-> block_active == blk_exp;
    endproperty
    a_block: assert property (p_block) else $error("block flags differ from elements");
    property p_hold;
        pins.line_store_strobe_n [*8] |-> $stable(line_image);
    endproperty
    a_hold: assert property (p_hold) else $error("line changed without store pulse");
    property p_stored;
        $fell(pins.line_store_strobe_n) |-> ##[1:6] status.line_stored;
    endproperty
    a_stored: assert property (p_stored) else $error("store pulse not taken");
    property p_count;
        bits_shifted < DOTS;
    endproperty
    a_count: assert property (p_count) else $error("bit count past line length");
    c_block: cover property (block_active != '0);
    c_store: cover property ($rose(status.line_stored));
    c_hot: cover property (hot_dots != '0 && status.heating);
endmodule : thermal_head_line_asserts

bind thermal_head_line thermal_head_line_asserts #(.DOTS(DOTS), .BLOCKS(BLOCKS),
    .BLOCK_DOTS(BLOCK_DOTS), .CNT_W(CNT_W)) chk (.clk(clk), .rstn(rstn),
    .shift_clk(shift_clk), .shift_rstn(shift_rstn), .pins(pins), .element_on(element_on),
    .block_active(block_active), .line_image(line_image), .hot_dots(hot_dots),
    .status(status), .bits_shifted(bits_shifted));

// file: tb/host_model.sv
// controller model driving the head pins and the shift clock
`timescale 1ns/1ps
module host_model
#(
    parameter int TAKEUP_STEPS = 48,
    parameter int FIRST_STEP_NS = 1000,
    parameter int PRINT_STEP_NS = 500,
    parameter int DOT_STEP_NS = 10,
    parameter int STEPS_PER_LINE = 2,
    parameter int RAMP_STEPS = 4,
    parameter int PAUSE_NS = 5000
)
(
    input wire logic clk,
    output logic shift_clk,
    output thermal_head_pkg::head_pins_t pins
);
    int step_ns;
    // shift clock stands low between lines, store pin idles high
    initial
    begin
        shift_clk = 1'b0;
        pins = 3'h2;
        step_ns = FIRST_STEP_NS;
    end
    // one motor step of the given period; the head pins are left alone
    task automatic motor_step(input int period_ns);
        #(period_ns);
    endtask : motor_step
    // steady feed at the first acceleration rate winds out the gear backlash
    task automatic take_up_feed();
        repeat (TAKEUP_STEPS) motor_step(FIRST_STEP_NS);
    endtask : take_up_feed
    // rate from the dot count and the heat time, never so fast that a heat
    // pulse outlasts two steps
    task automatic start_print(input int heat_ns, input int dots);
        step_ns = PRINT_STEP_NS + dots * DOT_STEP_NS;
        if (2 * step_ns < heat_ns)
        begin
            step_ns = (heat_ns + 1) / 2;
        end
        for (int i = RAMP_STEPS; i > 0; i--)
        begin
            motor_step(step_ns + i * FIRST_STEP_NS / RAMP_STEPS);
        end
    endtask : start_print
    // a dot line of unheated feed, the stop steps, then a rest before new work
    task automatic stop_print();
        repeat (STEPS_PER_LINE) motor_step(step_ns);
        for (int i = 1; i <= RAMP_STEPS; i++)
        begin
            motor_step(step_ns + i * FIRST_STEP_NS / RAMP_STEPS);
        end
        #(PAUSE_NS);
    endtask : stop_print
    // dot one goes first, so it ends at the far end of the register
    task automatic send_line(input logic [383:0] img);
        for (int i = 383; i >= 0; i--)
        begin
            pins.serial_dot_input = img[i];
            #15 shift_clk = 1'b1;
            #15 shift_clk = 1'b0;
        end
        // released data shows the opposite level, never a stale one
        pins.serial_dot_input = ~img[0];
    endtask : send_line
    // store only once shifting stopped; low four clocks for the sync
    task automatic store_line();
        @(negedge clk);
        pins.line_store_strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        pins.line_store_strobe_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask : store_line
    // heat only a stored line; heated bench images stay under 45 dots
    task automatic set_heat(input logic on);
        @(negedge clk);
        pins.heat_strobe = on;
    endtask : set_heat
endmodule : host_model

// file: tb/testbench.sv
// self-checking bench for the thermal head line logic
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rstn;
    logic shift_rstn;
    logic shift_clk;
    thermal_head_pkg::head_pins_t pins;
    logic [383:0] element_on;
    logic [5:0] block_active;
    logic [383:0] line_image;
    logic [8:0] hot_dots;
    thermal_head_pkg::head_status_t status;
    logic [8:0] bits_shifted;
    logic [383:0] img1;
    logic [383:0] img2;
    int errors = 0;
    int comparisons = 0;
    host_model host (.clk(clk), .shift_clk(shift_clk), .pins(pins));
    thermal_head_line dut (.clk(clk), .rstn(rstn), .shift_clk(shift_clk),
        .shift_rstn(shift_rstn), .pins(pins), .element_on(element_on),
        .block_active(block_active), .line_image(line_image), .hot_dots(hot_dots),
        .status(status), .bits_shifted(bits_shifted));
    // system clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [383:0] exp, input logic [383:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    // first, last and one inner dot land at their places
    task automatic test_order();
        img1 = 384'h0;
        img1[383] = 1'b1;
        img1[10] = 1'b1;
        img1[0] = 1'b1;
        host.send_line(img1);
        host.store_line();
        check("line_image", img1, line_image);
        check("bits_shifted", 384'h0, 384'(bits_shifted));
        check("element_on idle", 384'h0, element_on);
        check("line_stored", 384'h1, 384'(status.line_stored));
        $display("test_order done");
    endtask : test_order
    // heat lights only stored dots, in blocks one and six only
    task automatic test_heat();
        host.start_print(600, 3);
        host.set_heat(1'b1);
        repeat (5) @(negedge clk);
        check("element_on", img1, element_on);
        check("block_active", 384'h21, 384'(block_active));
        check("hot_dots", 384'h3, 384'(hot_dots));
        check("heating", 384'h1, 384'(status.heating));
        check("over_limit", 384'h0, 384'(status.over_limit));
        host.set_heat(1'b0);
        repeat (5) @(negedge clk);
        check("element_on off", 384'h0, element_on);
        check("block_active off", 384'h0, 384'(block_active));
        check("heating off", 384'h0, 384'(status.heating));
        host.stop_print();
        $display("test_heat done");
    endtask : test_heat
    // a new line shifted in stays hidden until the store pulse
    task automatic test_hold();
        img2 = {6{64'h0123456789ABCDEF}};
        host.send_line(img2);
        repeat (4) @(negedge clk);
        check("line_image held", img1, line_image);
        host.store_line();
        check("line_image new", img2, line_image);
        check("element_on unheated", 384'h0, element_on);
        check("hot_dots new", 384'hC0, 384'(hot_dots));
        check("over_limit new", 384'h1, 384'(status.over_limit));
        $display("test_hold done");
    endtask : test_hold
    // a reset in mid-run clears the stored line
    task automatic test_reset();
        @(negedge clk);
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        check("line_image reset", 384'h0, line_image);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        check("line_image after", 384'h0, line_image);
        $display("test_reset done");
    endtask : test_reset
    // reset both domains, then run the scenarios
    initial
    begin
        rstn = 1'b0;
        shift_rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        shift_rstn = 1'b1;
        repeat (2) @(negedge clk);
        host.take_up_feed();
        test_order();
        test_heat();
        test_hold();
        test_reset();
        print_verdict();
    end
    // watchdog: the run needs about 90 us including the take-up feed
    initial
    begin
        #300000;
        errors++;
        print_verdict();
    end
endmodule : testbench
